// File: ptg_port.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "ptg_regs.svh"
// Summary of operation
// R1: direction bit 1 makes a port bit output, 0 input, per bit.
// R2: pull-up on only when bit is input and latch is 1.
// R3: output 0 drives low; 1 drives high or releases if open-drain.
// R4: plain read of latch register returns the eight pin levels.
// R5: read-modify-write reads return the latch contents instead of pins.
// R6: channel b edge select bits 7:6: none, fall, rise, both.
// R7: channel a edge select bits 3:2 with the same encoding.
// R8: channel b flag bit 5 set by hardware on a matching edge.
// R9: channel a flag bit 1 set by hardware on a matching edge.
// R10: flags are cleared only by software writes, never automatically.
// R11: channel b flag and enable give standby release and vector 001b.
// R12: channel a flag and enable give standby release and vector 0013.
// R13: in deep standby edges still set flags; wake only if enabled.
// R14: in deep standby, edges toward the level held at entry are ignored.
// R15: software should use both-edge mode to wake from deep standby.
// R16: after pin wake, light standby on rc clock until irq accepted.
// R17: channel a pin from bits 3:0, channel b from bits 7:4.
// R18: each channel pin can clock timer 1 or trigger timer 0 capture.
// R19: pin select 3:2 picks a pin 0-3, 7:6 picks pin 4-7.
// R20: function select 00 none, 01 count, 10 low capture, 11 high.
// R21: simultaneous events on both channels to one function count once.
// R22: pins synchronised; edges found by comparing with previous sample.
module ptg_port
    import ptg_pkg::*;
#(
    parameter int        WIDTH      = 8,
    parameter bit [7:0]  OPEN_DRAIN = 8'h00
) (
    // clocking
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,
    // register port
    input  wire logic [`PTG_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic                   reg_rmw,
    output logic      [7:0]             reg_rdata,
    // port pins
    input  wire logic [WIDTH-1:0]       pin_in,
    output logic      [WIDTH-1:0]       pin_out,
    output logic      [WIDTH-1:0]       pin_oe,
    output logic      [WIDTH-1:0]       pin_pullup,
    // core power handshake
    input  wire logic                   deep_standby_enter,
    input  wire logic                   irq_accept,
    output logic                        deep_release,
    output logic                        rc_clock_sel,
    // interrupt requests
    output logic                        pin_irq_a,
    output logic                        pin_irq_b,
    output logic      [15:0]            irq_vector,
    // timer routing
    output logic                        t1_count_clk,
    output logic                        t0l_capture,
    output logic                        t0h_capture
);

    // ***********************************************
    // registers and wires
    // ***********************************************
    logic [7:0] port_two_output_latch_reg;
    logic [7:0] port_two_direction_reg;
    logic [7:0] ext_irq_edge_control_reg;
    logic [7:0] ext_irq_pin_select_reg;
    logic [7:0] rdata_next;
    logic [7:0] edge_next;
    ptg_pwr_e   pwr_reg;
    ptg_pwr_e   pwr_next;
    logic       t1_reg;
    logic       t0l_reg;
    logic       t0h_reg;
    logic [WIDTH-1:0] pin_sync;
    logic       hit_a;
    logic       hit_b;
    logic       sel_latch;
    logic       sel_dir;
    logic       sel_edge;
    logic       sel_pinsel;
    logic       sel_ctrl;
    logic       wr_edge;
    logic       req_a;
    logic       req_b;
    logic       deep_entry;
    logic       in_deep;
    ptg_func_e  func_a;
    ptg_func_e  func_b;
    logic       t1_next;
    logic       t0l_next;
    logic       t0h_next;

    // ***********************************************
    // address decode
    // ***********************************************
    assign sel_latch  = (reg_addr == `PTG_OFS_LATCH);
    assign sel_dir    = (reg_addr == `PTG_OFS_DIR);
    assign sel_edge   = (reg_addr == `PTG_OFS_EDGE);
    assign sel_pinsel = (reg_addr == `PTG_OFS_PINSEL);
    assign sel_ctrl   = (reg_addr == `PTG_OFS_CTRL);
    assign wr_edge    = reg_wr & sel_edge;

    // ***********************************************
    // pin drive
    // ***********************************************
    // per-bit drive, release and pull-up
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            // open-drain bits only drive when latch is 0
            assign pin_oe[gi] = port_two_direction_reg[gi] &                 // R1
                                ~(OPEN_DRAIN[gi] & port_two_output_latch_reg[gi]); // R3
            assign pin_out[gi]    = port_two_output_latch_reg[gi];           // R3
            assign pin_pullup[gi] = ~port_two_direction_reg[gi] &
                                    port_two_output_latch_reg[gi];           // R2
        end
    endgenerate

    // inputs sampled in regardless of direction
    ptg_sync #(
        .W (WIDTH)
    ) u_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in (pin_in),
        .sync_out (pin_sync)                                                 // R22
    );

    // ***********************************************
    // edge channels
    // ***********************************************
    assign deep_entry = deep_standby_enter & (pwr_reg == PTG_RUN);
    assign in_deep    = (pwr_reg == PTG_DEEP);

    ptg_edge_chan u_chan_a (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .clk_en     (clk_en),
        .pins       (pin_sync[3:0]),                                         // R17
        .pin_sel    (ext_irq_pin_select_reg[3:2]),                           // R19
        .rise_en    (ext_irq_edge_control_reg[`PTG_A_RISE]),                 // R7
        .fall_en    (ext_irq_edge_control_reg[`PTG_A_FALL]),
        .deep_entry (deep_entry),
        .in_deep    (in_deep),
        .edge_hit   (hit_a)
    );

    ptg_edge_chan u_chan_b (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .clk_en     (clk_en),
        .pins       (pin_sync[7:4]),                                         // R17
        .pin_sel    (ext_irq_pin_select_reg[7:6]),                           // R19
        .rise_en    (ext_irq_edge_control_reg[`PTG_B_RISE]),                 // R6
        .fall_en    (ext_irq_edge_control_reg[`PTG_B_FALL]),
        .deep_entry (deep_entry),
        .in_deep    (in_deep),
        .edge_hit   (hit_b)
    );

    // ***********************************************
    // flags and requests
    // ***********************************************
    // software write first, then hardware set so a coincident edge wins
    always_comb begin
        edge_next = wr_edge ? reg_wdata : ext_irq_edge_control_reg;          // R10
        if (hit_a) begin
            edge_next[`PTG_A_FLAG] = 1'b1;                                   // R9 R13
        end
        if (hit_b) begin
            edge_next[`PTG_B_FLAG] = 1'b1;                                   // R8 R13
        end
    end

    assign req_a = ext_irq_edge_control_reg[`PTG_A_FLAG] &
                   ext_irq_edge_control_reg[`PTG_A_EN];                      // R12
    assign req_b = ext_irq_edge_control_reg[`PTG_B_FLAG] &
                   ext_irq_edge_control_reg[`PTG_B_EN];                      // R11
    assign pin_irq_a    = req_a;
    assign pin_irq_b    = req_b;
    assign deep_release = req_a | req_b;                                     // R11 R12 R13
    // channel a has the lower vector and so the higher priority
    assign irq_vector   = req_a ? `PTG_VEC_A : (req_b ? `PTG_VEC_B : 16'h0000);
    assign rc_clock_sel = (pwr_reg == PTG_LIGHT);                            // R16

    // ***********************************************
    // power state
    // ***********************************************
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PTG_RUN: begin
                if (deep_standby_enter) begin
                    pwr_next = PTG_DEEP;
                end
            end
            PTG_DEEP: begin
                if (deep_release) begin
                    pwr_next = PTG_LIGHT;                                    // R16
                end
            end
            PTG_LIGHT: begin
                if (irq_accept) begin
                    pwr_next = PTG_RUN;                                      // R16
                end
            end
            default: begin
                pwr_next = PTG_RUN;
            end
        endcase
    end

    // ***********************************************
    // timer routing
    // ***********************************************
    assign func_a = ptg_func_e'(ext_irq_pin_select_reg[1:0]);                // R20
    assign func_b = ptg_func_e'(ext_irq_pin_select_reg[5:4]);                // R20
    // or-merge means coincident events yield a single pulse
    assign t1_next  = (hit_a & (func_a == PTG_FN_T1_CLK)) |
                      (hit_b & (func_b == PTG_FN_T1_CLK));                   // R18 R21
    assign t0l_next = (hit_a & (func_a == PTG_FN_T0L_CAP)) |
                      (hit_b & (func_b == PTG_FN_T0L_CAP));                  // R18 R21
    assign t0h_next = (hit_a & (func_a == PTG_FN_T0H_CAP)) |
                      (hit_b & (func_b == PTG_FN_T0H_CAP));                  // R18 R21
    assign t1_count_clk = t1_reg;
    assign t0l_capture  = t0l_reg;
    assign t0h_capture  = t0h_reg;

    // ***********************************************
    // read mux
    // ***********************************************
    // rmw cycles see the latch so untouched output bits keep their value
    always_comb begin
        rdata_next = 8'h00;
        if (sel_latch) begin
            rdata_next = reg_rmw ? port_two_output_latch_reg                 // R5
                                 : pin_sync;                                 // R4
        end else if (sel_dir) begin
            rdata_next = port_two_direction_reg;
        end else if (sel_edge) begin
            rdata_next = ext_irq_edge_control_reg;
        end else if (sel_pinsel) begin
            rdata_next = ext_irq_pin_select_reg;
        end else if (sel_ctrl) begin
            rdata_next = {6'h00, rc_clock_sel, in_deep};
        end
    end

    // ***********************************************
    // state update
    // ***********************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port_two_output_latch_reg <= `PTG_RST_BYTE;
            port_two_direction_reg    <= `PTG_RST_BYTE;
            ext_irq_edge_control_reg  <= `PTG_RST_BYTE;
            ext_irq_pin_select_reg    <= `PTG_RST_BYTE;
            reg_rdata                 <= 8'h00;
            pwr_reg                   <= PTG_RUN;
            t1_reg                    <= 1'b0;
            t0l_reg                   <= 1'b0;
            t0h_reg                   <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr & sel_latch) begin
                port_two_output_latch_reg <= reg_wdata;
            end
            if (reg_wr & sel_dir) begin
                port_two_direction_reg <= reg_wdata;                         // R1
            end
            if (reg_wr & sel_pinsel) begin
                ext_irq_pin_select_reg <= reg_wdata;
            end
            ext_irq_edge_control_reg <= edge_next;
            reg_rdata <= reg_rd ? rdata_next : 8'h00;
            pwr_reg   <= pwr_next;
            t1_reg    <= t1_next;
            t0l_reg   <= t0l_next;
            t0h_reg   <= t0h_next;
        end
    end

endmodule : ptg_port

// File: ptg_regs.svh
`ifndef PTG_REGS_SVH
`define PTG_REGS_SVH

// ***********************************************
// register offsets
// ***********************************************
`define PTG_ADDR_W          16
`define PTG_OFS_LATCH       16'hfe48
`define PTG_OFS_DIR         16'hfe49
`define PTG_OFS_EDGE        16'hfe4a
`define PTG_OFS_PINSEL      16'hfe4b
`define PTG_OFS_CTRL        16'hfe4f

// ***********************************************
// field positions
// ***********************************************
`define PTG_B_RISE          7
`define PTG_B_FALL          6
`define PTG_B_FLAG          5
`define PTG_B_EN            4
`define PTG_A_RISE          3
`define PTG_A_FALL          2
`define PTG_A_FLAG          1
`define PTG_A_EN            0
`define PTG_CTRL_STBY       0
`define PTG_CTRL_RMW        1

// ***********************************************
// reset values
// ***********************************************
`define PTG_RST_BYTE        8'h00

// ***********************************************
// vectors
// ***********************************************
`define PTG_VEC_A           16'h0013
`define PTG_VEC_B           16'h001b

`endif

// File: ptg_pkg.sv
package ptg_pkg;

    // extra function routed from a channel pin
    typedef enum logic [1:0] {
        PTG_FN_NONE,
        PTG_FN_T1_CLK,
        PTG_FN_T0L_CAP,
        PTG_FN_T0H_CAP
    } ptg_func_e;

    // core power state as seen by the port
    typedef enum logic [1:0] {
        PTG_RUN,
        PTG_DEEP,
        PTG_LIGHT
    } ptg_pwr_e;

endpackage : ptg_pkg

// File: ptg_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser, one stage pair per bit
module ptg_sync #(
    parameter int W = 8
) (
    // clocking
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    // data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : ptg_sync

// File: ptg_edge_chan.sv
`timescale 1ns/1ps
`include "ptg_regs.svh"
// one pin-interrupt channel: pin select, edge detect, standby masking
module ptg_edge_chan
    import ptg_pkg::*;
(
    // clocking
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // selection
    input  wire logic [3:0] pins,
    input  wire logic [1:0] pin_sel,
    input  wire logic       rise_en,
    input  wire logic       fall_en,
    // standby
    input  wire logic       deep_entry,
    input  wire logic       in_deep,
    // event out
    output logic            edge_hit
);

    logic sample_reg;
    logic entry_lvl_reg;
    logic cur;
    logic rise;
    logic fall;
    logic rise_ok;
    logic fall_ok;

    // selection and edge decode, comparing against previous sample
    assign cur  = pins[pin_sel];                          // R17 R19
    assign rise = cur & ~sample_reg;                      // R22
    assign fall = ~cur & sample_reg;                      // R22
    // in deep standby an edge toward the entry level never counts, all the way
    // through; only the opposite edge wakes, hence the advice to use both edges
    assign rise_ok  = ~(in_deep & entry_lvl_reg);               // R14
    assign fall_ok  = ~(in_deep & ~entry_lvl_reg);              // R14
    assign edge_hit = (rise_en & rise & rise_ok) | (fall_en & fall & fall_ok); // R6 R7

    // previous sample and level caught at standby entry
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sample_reg    <= 1'b0;
            entry_lvl_reg <= 1'b0;
        end else if (clk_en) begin
            sample_reg <= cur;
            if (deep_entry) begin
                entry_lvl_reg <= cur;
            end
        end
    end

endmodule : ptg_edge_chan

// File: ptg_port_sva.sv
`timescale 1ns/1ps
`include "ptg_regs.svh"
// checker on the port pins, power handshake and read port
module ptg_port_sva (
    // clocking
    input wire logic                   sys_clk,
    input wire logic                   sys_rst,
    // register port
    input wire logic [`PTG_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic                   reg_rmw,
    input wire logic [7:0]             reg_rdata,
    // pins
    input wire logic [7:0]             pin_out,
    input wire logic [7:0]             pin_oe,
    input wire logic [7:0]             pin_pullup,
    // power and requests
    input wire logic                   irq_accept,
    input wire logic                   deep_release,
    input wire logic                   rc_clock_sel,
    input wire logic                   pin_irq_a,
    input wire logic                   pin_irq_b,
    input wire logic [15:0]            irq_vector
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // only an edge-control write may lower a request
    wire wr_edge = reg_wr && (reg_addr == `PTG_OFS_EDGE);
    sequence s_rmw_rd;
        reg_rd && reg_rmw && (reg_addr == `PTG_OFS_LATCH);
    endsequence
    sequence s_light;
        rc_clock_sel && !irq_accept;
    endsequence
    property p_pullup; pin_pullup == (~pin_oe & pin_out); endproperty
    property p_rmw; s_rmw_rd |=> reg_rdata == $past(pin_out); endproperty
    property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    property p_rel; deep_release == (pin_irq_a || pin_irq_b); endproperty
    property p_vec;
        irq_vector == (pin_irq_a ? `PTG_VEC_A : (pin_irq_b ? `PTG_VEC_B : 16'h0000));
    endproperty
    property p_stk_a; $fell(pin_irq_a) && !$past(sys_rst) |-> $past(wr_edge); endproperty
    property p_stk_b; $fell(pin_irq_b) && !$past(sys_rst) |-> $past(wr_edge); endproperty
    property p_wake; $rose(rc_clock_sel) |-> $past(deep_release); endproperty
    property p_hold; s_light |=> rc_clock_sel; endproperty
    property p_exit; rc_clock_sel && irq_accept |=> !rc_clock_sel; endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up mismatch");
    a_rmw: assert property (p_rmw) else $error("rmw read not latch");
    a_idle: assert property (p_idle) else $error("read data not idle");
    a_rel: assert property (p_rel) else $error("release mismatch");
    a_vec: assert property (p_vec) else $error("vector mismatch");
    a_stk_a: assert property (p_stk_a) else $error("request a dropped");
    a_stk_b: assert property (p_stk_b) else $error("request b dropped");
    a_wake: assert property (p_wake) else $error("wake without release");
    a_hold: assert property (p_hold) else $error("light standby left");
    a_exit: assert property (p_exit) else $error("light standby kept");
endmodule : ptg_port_sva
bind ptg_port ptg_port_sva u_sva (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_rmw, .reg_rdata, .pin_out, .pin_oe, .pin_pullup, .irq_accept, .deep_release,
    .rc_clock_sel, .pin_irq_a, .pin_irq_b, .irq_vector);

// File: ptg_board.sv
`timescale 1ns/1ps
// board side of the eight port pins
module ptg_board (
    // clocking
    input  wire logic       sys_clk,
    // device side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    // board drivers
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_en,
    // wire level
    output logic      [7:0] pin_lvl
);
    logic [7:0] flt_reg = 8'h55;
    // a floating pin wanders so it never reads as a settled level
    always @(posedge sys_clk) flt_reg <= ~flt_reg;
    // device driver first, then board, then pull-up
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
                   | (~pin_oe & ~ext_en & (pin_pullup | flt_reg));
endmodule : ptg_board

// File: ptg_port_tb.sv
`timescale 1ns/1ps
`include "ptg_regs.svh"
module ptg_port_tb;
    logic        sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, reg_rmw = 0;
    logic        deep_standby_enter = 0, irq_accept = 0, clk_en = 1;
    logic [15:0] reg_addr = 0;
    logic [7:0]  reg_wdata = 0, ext_drv = 0, ext_en = 8'hff;
    logic [7:0]  reg_rdata, pin_lvl, pin_out, pin_oe, pin_pullup;
    logic        deep_release, rc_clock_sel, pin_irq_a, pin_irq_b, t1, tl, th;
    logic [15:0] irq_vector;
    int          err_total = 0, checks = 0, cyc = 0, seed = 32'h27856eb5;
    int          n_t[3] = '{0, 0, 0}, e_t[3] = '{0, 0, 0};
    always #50 sys_clk = ~sys_clk;
    ptg_port uut (.sys_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rmw, .reg_rdata, .pin_in(pin_lvl), .pin_out, .pin_oe, .pin_pullup,
        .deep_standby_enter, .irq_accept, .deep_release, .rc_clock_sel, .pin_irq_a,
        .pin_irq_b, .irq_vector, .t1_count_clk(t1), .t0l_capture(tl), .t0h_capture(th));
    ptg_board u_board (.sys_clk, .pin_out, .pin_oe, .pin_pullup, .ext_drv, .ext_en,
        .pin_lvl);
    // timer pulse counters and hang guard
    always @(posedge sys_clk) begin
        n_t[0] += (t1 === 1'b1);
        n_t[1] += (tl === 1'b1);
        n_t[2] += (th === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    task results();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) reg_wr <= 0;
    endtask : wr
    // read strobe one cycle, data taken in the cycle after
    task cr(input string nm, input logic [15:0] a, input logic m, input logic [7:0] e);
        @(posedge sys_clk) {reg_addr, reg_rmw, reg_rd} <= {a, m, 1'b1};
        @(posedge sys_clk) {reg_rmw, reg_rd} <= 2'b00;
        #1 chk(nm, {8'h00, e}, {8'h00, reg_rdata});
    endtask : cr
    task pin(input int i, input logic v);
        @(posedge sys_clk) ext_drv[i] <= v;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : pin
    task pulse_acc();
        @(posedge sys_clk) irq_accept <= 1;
        @(posedge sys_clk) irq_accept <= 0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : pulse_acc
    function logic [7:0] lvl(input logic [7:0] dir, lat, drv);
        return (dir & lat) | (~dir & drv);
    endfunction : lvl
    function logic hit(input logic [1:0] md, input logic rise);
        return rise ? md[1] : md[0];
    endfunction : hit
    // ***********************************************
    // main sequence
    // ***********************************************
    initial begin
        logic [7:0] dir, lat, drv;
        logic       x;
        int         sh, sel, fn, p;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 0;
        cr("latch", `PTG_OFS_LATCH, 1, 8'h00);
        cr("dir", `PTG_OFS_DIR, 0, 8'h00);
        cr("edge", `PTG_OFS_EDGE, 0, 8'h00);
        cr("sel", `PTG_OFS_PINSEL, 0, 8'h00);
        wr(16'hfe4c, 8'hff);
        cr("unmapped", 16'hfe4c, 0, 8'h00);
        // random direction, latch and board levels, all-out and all-in first
        for (int k = 0; k < 16; k++) begin
            dir = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
            lat = 8'($random(seed));
            drv = 8'($random(seed));
            wr(`PTG_OFS_DIR, dir);
            wr(`PTG_OFS_LATCH, lat);
            ext_drv <= drv;
            repeat (4) @(posedge sys_clk);
            #1 chk("oe", {8'h00, dir}, {8'h00, pin_oe});
            chk("pullup", {8'h00, ~dir & lat}, {8'h00, pin_pullup});
            chk("drive", {8'h00, dir & lat}, {8'h00, pin_oe & pin_out});
            cr("pins", `PTG_OFS_LATCH, 0, lvl(dir, lat, drv));
            cr("rmw", `PTG_OFS_LATCH, 1, lat);
        end
        wr(`PTG_OFS_DIR, 8'h00);
        wr(`PTG_OFS_LATCH, 8'h00);
        ext_drv <= 8'h00;
        // a write while the clock enable is low must not land
        @(posedge sys_clk) clk_en <= 0;
        wr(`PTG_OFS_LATCH, 8'h5a);
        @(posedge sys_clk) clk_en <= 1;
        cr("frozen", `PTG_OFS_LATCH, 1, 8'h00);
        // every edge mode on both channels, random pin and function
        for (int ch = 0; ch < 2; ch++) begin
            for (int md = 0; md < 4; md++) begin
                sh = 4 * ch;
                sel = $random(seed) & 3;
                fn = $random(seed) & 3;
                p = sh + sel;
                wr(`PTG_OFS_PINSEL, 8'(((sel << 2) | fn) << sh));
                wr(`PTG_OFS_EDGE, 8'(((md << 2) | 1) << sh));
                for (int e = 1; e >= 0; e--) begin
                    pin(p, 1'(e));
                    x = hit(2'(md), 1'(e));
                    chk("irq", {15'h0, x}, {15'h0, ch ? pin_irq_b : pin_irq_a});
                    chk("vec", x ? (ch ? 16'h001b : 16'h0013) : 16'h0, irq_vector);
                    if (x && fn != 0) e_t[fn - 1]++;
                    for (int j = 0; j < 3; j++) chk("timer", 16'(e_t[j]), 16'(n_t[j]));
                    if (x) pulse_acc();
                    cr("flag", `PTG_OFS_EDGE, 0, 8'(((md << 2) | (x << 1) | 1) << sh));
                    wr(`PTG_OFS_EDGE, 8'(((md << 2) | 1) << sh));
                end
            end
        end
        // coincident events on both channels into the count clock
        wr(`PTG_OFS_PINSEL, 8'h11);
        wr(`PTG_OFS_EDGE, 8'hcc);
        @(posedge sys_clk) ext_drv <= 8'h11;
        repeat (6) @(posedge sys_clk);
        e_t[0]++;
        #1 chk("coincident", 16'(e_t[0]), 16'(n_t[0]));
        cr("both", `PTG_OFS_EDGE, 0, 8'hee);
        // deep standby: flag without wake, then wake once enabled
        wr(`PTG_OFS_PINSEL, 8'h00);
        wr(`PTG_OFS_EDGE, 8'h0c);
        @(posedge sys_clk) deep_standby_enter <= 1;
        @(posedge sys_clk) deep_standby_enter <= 0;
        cr("deep", `PTG_OFS_CTRL, 0, 8'h01);
        pin(0, 0);
        cr("deep_flag", `PTG_OFS_EDGE, 0, 8'h0e);
        cr("still_deep", `PTG_OFS_CTRL, 0, 8'h01);
        wr(`PTG_OFS_EDGE, 8'h0f);
        repeat (3) @(posedge sys_clk);
        #1 chk("rc_sel", 16'h1, {15'h0, rc_clock_sel});
        cr("light", `PTG_OFS_CTRL, 0, 8'h02);
        pulse_acc();
        chk("rc_off", 16'h0, {15'h0, rc_clock_sel});
        cr("run", `PTG_OFS_CTRL, 0, 8'h00);
        // deep entry with pin low: a later fall toward that level is masked
        wr(`PTG_OFS_EDGE, 8'h04);
        @(posedge sys_clk) deep_standby_enter <= 1;
        @(posedge sys_clk) deep_standby_enter <= 0;
        pin(0, 1);
        pin(0, 0);
        cr("deep_mask", `PTG_OFS_EDGE, 0, 8'h04);
        results();
    end
endmodule : ptg_port_tb
